//--- bcsc_ctrl.sv
// switching, mode selection and current-limit control core of the step-down converter
//
// Function
// R1 - fixed-frequency cycle starts high-side until regulation trip
// R2 - high-side limit: high-side off, low-side on
// R3 - low-side limit holds low-side, blocks pulses
// R4 - power-save idles until output below threshold
// R5 - power-save burst ends at output above nominal
// R6 - mode low: automatic fixed-frequency or power-save
// R7 - mode high: forced fixed-frequency, no power-save
// R8 - mode changes on the fly, no restart
// R9 - other party drives about 3 MHz sync clock
// R10 - sync clock: fixed-frequency, start on falling edge
// R11 - current limit rises in four steps
// R12 - step advances every 256 internal clocks
// R13 - hold second step until output above half
// R14 - enable high starts at first soft-start step
// R15 - enable low: switches off, control idle
// R16 - output below half: half current limit
// R17 - synchronous comparator inputs, gates never both on
module bcsc_ctrl #(
  parameter int SS_STEP_TICKS = bcsc_pkg::SS_STEP_TICKS
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // device pins
  input  wire logic                              en,
  input  wire logic                              mode_sync,
  // comparator results
  input  wire logic                              reg_cmp_trip,
  input  wire logic                              hs_ilim,
  input  wire logic                              ls_ilim,
  input  wire logic                              vout_below_ps,
  input  wire logic                              vout_above_nom,
  input  wire logic                              vout_above_half,
  input  wire logic                              light_load,
  // switch commands and current limit setting
  output logic                                   hs_gate,
  output logic                                   ls_gate,
  output logic [bcsc_pkg::ILIM_W-1:0]            ilim_ma,
  // register port
  input  wire logic [bcsc_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic [31:0]                            reg_rdata
);

  bcsc_ss_if ss_link ();

  bcsc_pkg::bcsc_state_e           state;
  bcsc_pkg::bcsc_state_e           next_state;
  logic [bcsc_pkg::OSC_W-1:0]      osc_cnt;
  logic                            osc_tick;
  logic                            mode_prev;
  logic                            sync_fall;
  logic [bcsc_pkg::SYNC_W-1:0]     since_edge;
  logic                            sync_present;
  logic                            cycle_start;
  logic                            ps_enable;
  logic                            auto_mode;
  logic                            forced_pwm;
  logic                            ps_active;
  logic                            burst;
  logic                            start_ok;
  logic                            running;
  logic [bcsc_pkg::CNT_W-1:0]      pulse_cnt;
  logic [bcsc_pkg::CNT_W-1:0]      ilim_cnt;
  logic                            pulse_evt;
  logic                            ilim_evt;
  logic                            cnt_clear;

  // limit for a soft-start step
  function automatic logic [bcsc_pkg::ILIM_W-1:0] step_limit(input logic [1:0] s);
    logic [bcsc_pkg::ILIM_W-1:0] v;
    v = bcsc_pkg::ILIM_FULL_MA;
    unique case (s)
      2'h0: v = bcsc_pkg::ILIM_STEP0_MA;
      2'h1: v = bcsc_pkg::ILIM_STEP1_MA;
      2'h2: v = bcsc_pkg::ILIM_STEP2_MA;
      2'h3: v = bcsc_pkg::ILIM_FULL_MA;
    endcase
    return v;
  endfunction

  assign running = rst_n && en;

  // internal oscillator, also the soft-start clock
  always_ff @(posedge sys_clk)
  begin
    if (!running) // R15
      osc_cnt <= '0;
    else if (osc_cnt == bcsc_pkg::OSC_LAST) // R1
      osc_cnt <= '0;
    else
      osc_cnt <= osc_cnt + 1'b1;
  end

  assign osc_tick = running && (osc_cnt == bcsc_pkg::OSC_LAST);

  // external clock detection on the mode input
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      mode_prev <= mode_sync; // a pin idling high gives no false edge out of reset
    else
      mode_prev <= mode_sync; // R17
  end

  assign sync_fall = mode_prev && !mode_sync;

  always_ff @(posedge sys_clk)
  begin
    if (!running)
      since_edge <= bcsc_pkg::SYNC_LOSS;
    else if (mode_prev != mode_sync)
      since_edge <= '0;
    else if (since_edge != bcsc_pkg::SYNC_LOSS)
      since_edge <= since_edge + 1'b1;
  end

  // any edge within the loss window counts as a clock
  assign sync_present = (since_edge != bcsc_pkg::SYNC_LOSS);

  // a pulse starts at the falling sync edge when a clock is there
  assign cycle_start = sync_present ? sync_fall : osc_tick; // R10

  assign forced_pwm = sync_present || mode_sync || !ps_enable; // R7
  assign auto_mode  = !forced_pwm; // R6

  // power-save selection follows the mode input without a restart
  always_ff @(posedge sys_clk)
  begin
    if (!running)
      ps_active <= 1'b0;
    else
      ps_active <= auto_mode && light_load; // R8
  end

  // burst window inside power-save, wake wins over the end
  always_ff @(posedge sys_clk)
  begin
    if (!running || !ps_active)
      burst <= 1'b0;
    else if (vout_below_ps) // R4
      burst <= 1'b1;
    else if (vout_above_nom) // R5
      burst <= 1'b0;
  end

  assign start_ok = cycle_start && !ls_ilim && (!ps_active || burst); // R3

  // switching sequence
  always_comb
  begin
    next_state = state;
    unique case (state)
      bcsc_pkg::ST_OFF:
        next_state = bcsc_pkg::ST_IDLE; // R14
      bcsc_pkg::ST_IDLE:
      begin
        if (start_ok)
          next_state = bcsc_pkg::ST_HS; // R1
      end
      bcsc_pkg::ST_HS:
      begin
        if (hs_ilim) // R2
          next_state = bcsc_pkg::ST_LS;
        else if (reg_cmp_trip) // R1
          next_state = bcsc_pkg::ST_LS;
        else if (ps_active && vout_above_nom) // R5
          next_state = bcsc_pkg::ST_LS;
      end
      bcsc_pkg::ST_LS:
      begin
        if (ls_ilim) // R3
          next_state = bcsc_pkg::ST_LS;
        else if (ps_active && !burst) // R5
          next_state = bcsc_pkg::ST_IDLE;
        else if (start_ok)
          next_state = bcsc_pkg::ST_HS;
      end
    endcase
    if (!running)
      next_state = bcsc_pkg::ST_OFF; // R15
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= bcsc_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // gate commands decoded from one state, so never both on
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
    end
    else
    begin
      hs_gate <= (next_state == bcsc_pkg::ST_HS); // R17
      ls_gate <= (next_state == bcsc_pkg::ST_LS); // R17
    end
  end

  // soft-start sequencer
  assign ss_link.tick      = osc_tick;
  assign ss_link.restart   = !running; // R14
  assign ss_link.vout_half = vout_above_half;

  bcsc_softstart #(
    .STEP_TICKS (SS_STEP_TICKS)
  ) u_softstart (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ss      (ss_link.seq)
  );

  // current limit: step value, capped at half of full while the output is low
  always_ff @(posedge sys_clk)
  begin
    if (!running)
      ilim_ma <= bcsc_pkg::ILIM_STEP0_MA;
    else if (!vout_above_half && step_limit(ss_link.step) > bcsc_pkg::ILIM_HALF_MA) // R16
      ilim_ma <= bcsc_pkg::ILIM_HALF_MA;
    else
      ilim_ma <= step_limit(ss_link.step); // R11
  end

  // event counters, a write to the counter word clears them
  assign pulse_evt = (state != bcsc_pkg::ST_HS) && (next_state == bcsc_pkg::ST_HS);
  assign ilim_evt  = (state == bcsc_pkg::ST_HS) && hs_ilim;
  assign cnt_clear = reg_wr && (reg_addr == bcsc_pkg::ADDR_COUNT);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pulse_cnt <= '0;
    else if (cnt_clear)
      pulse_cnt <= pulse_evt ? bcsc_pkg::CNT_W'(1) : '0;
    else if (pulse_evt)
      pulse_cnt <= pulse_cnt + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ilim_cnt <= '0;
    else if (cnt_clear)
      ilim_cnt <= ilim_evt ? bcsc_pkg::CNT_W'(1) : '0;
    else if (ilim_evt)
      ilim_cnt <= ilim_cnt + 1'b1;
  end

  // control register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ps_enable <= bcsc_pkg::CTRL_RESET[bcsc_pkg::CTRL_PS_EN_BIT];
    else if (reg_wr && reg_addr == bcsc_pkg::ADDR_CTRL)
      ps_enable <= reg_wdata[bcsc_pkg::CTRL_PS_EN_BIT];
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        bcsc_pkg::ADDR_CTRL:
          reg_rdata[bcsc_pkg::CTRL_PS_EN_BIT] <= ps_enable;
        bcsc_pkg::ADDR_STATUS:
        begin
          reg_rdata[bcsc_pkg::ST_STEP_LSB +: 2]  <= ss_link.step;
          reg_rdata[bcsc_pkg::ST_STATE_LSB +: 2] <= state;
          reg_rdata[bcsc_pkg::ST_PS_BIT]         <= ps_active;
          reg_rdata[bcsc_pkg::ST_BURST_BIT]      <= burst;
          reg_rdata[bcsc_pkg::ST_SYNC_BIT]       <= sync_present;
          reg_rdata[bcsc_pkg::ST_DONE_BIT]       <= ss_link.done;
          reg_rdata[bcsc_pkg::ST_HALF_BIT]       <= !vout_above_half;
          reg_rdata[bcsc_pkg::ST_FORCED_BIT]     <= forced_pwm;
        end
        bcsc_pkg::ADDR_ILIM:
          reg_rdata[bcsc_pkg::ILIM_W-1:0] <= ilim_ma;
        bcsc_pkg::ADDR_COUNT:
        begin
          reg_rdata[bcsc_pkg::CNT_W-1:0]                      <= pulse_cnt;
          reg_rdata[bcsc_pkg::CNT_ILIM_LSB +: bcsc_pkg::CNT_W] <= ilim_cnt;
        end
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // bcsc_ctrl

//--- bcsc_pkg.sv
// shared constants and types for the buck converter mode and soft-start controller
package bcsc_pkg;

  // clock and switching timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CLK_KHZ        = 100000;
  localparam int SW_FREQ_KHZ    = 3000;
  localparam int SW_PERIOD_CYC  = (CLK_KHZ / SW_FREQ_KHZ) < 1 ? 1 : (CLK_KHZ / SW_FREQ_KHZ);
  localparam int OSC_W          = 6;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(SW_PERIOD_CYC - 1);

  // loss of external clock on the mode input after this long without an edge
  localparam int SYNC_LOSS_NS   = 700;
  localparam int SYNC_LOSS_CYC  = (SYNC_LOSS_NS / CLK_PERIOD_NS) < 1 ? 1 : (SYNC_LOSS_NS / CLK_PERIOD_NS);
  localparam int SYNC_W         = 8;
  localparam logic [SYNC_W-1:0] SYNC_LOSS = SYNC_W'(SYNC_LOSS_CYC);

  // soft-start step length in internal oscillator clocks
  localparam int SS_STEP_TICKS  = 256;
  localparam int SS_CNT_W       = 16;

  // current limit steps in mA
  localparam int ILIM_W         = 10;
  localparam logic [ILIM_W-1:0] ILIM_STEP0_MA = 10'h0c3;
  localparam logic [ILIM_W-1:0] ILIM_STEP1_MA = 10'h186;
  localparam logic [ILIM_W-1:0] ILIM_STEP2_MA = 10'h249;
  localparam logic [ILIM_W-1:0] ILIM_FULL_MA  = 10'h30c;
  localparam logic [ILIM_W-1:0] ILIM_HALF_MA  = ILIM_FULL_MA >> 1;

  // register map
  localparam int ADDR_W         = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_ILIM   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h0c;

  // control fields and reset value
  localparam int CTRL_PS_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status fields
  localparam int ST_STEP_LSB    = 0;
  localparam int ST_STATE_LSB   = 2;
  localparam int ST_PS_BIT      = 4;
  localparam int ST_BURST_BIT   = 5;
  localparam int ST_SYNC_BIT    = 6;
  localparam int ST_DONE_BIT    = 7;
  localparam int ST_HALF_BIT    = 8;
  localparam int ST_FORCED_BIT  = 9;

  // event counters
  localparam int CNT_W          = 16;
  localparam int CNT_ILIM_LSB   = 16;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_IDLE = 2'b01,
    ST_HS   = 2'b11,
    ST_LS   = 2'b10
  } bcsc_state_e;

endpackage

//--- bcsc_ss_if.sv
// link between the switching controller and the soft-start sequencer
interface bcsc_ss_if;
  logic       tick;
  logic       restart;
  logic       vout_half;
  logic [1:0] step;
  logic       done;

  modport seq (input tick, input restart, input vout_half, output step, output done);
  modport ctl (output tick, output restart, output vout_half, input step, input done);
endinterface

//--- bcsc_softstart.sv
// stepped soft-start sequencer raising the current limit
module bcsc_softstart #(
  parameter int STEP_TICKS = bcsc_pkg::SS_STEP_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // controller side
  bcsc_ss_if.seq   ss
);

  logic [bcsc_pkg::SS_CNT_W-1:0] cnt;
  logic [1:0]                    step;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || ss.restart)
    begin
      cnt  <= '0;
      step <= 2'h0; // R14
    end
    else if (ss.tick && step != 2'h3)
    begin
      if (cnt == bcsc_pkg::SS_CNT_W'(STEP_TICKS - 1)) // R12
      begin
        cnt <= '0;
        // hold at the second step until the output passes half of nominal
        if (step != 2'h1 || ss.vout_half) // R13
          step <= step + 2'h1; // R11
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

  assign ss.step = step;
  assign ss.done = (step == 2'h3);

endmodule // bcsc_softstart

//--- bcsc_ctrl_monitor.sv
// port checker for the converter control core
module bcsc_ctrl_monitor (
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  // pins and comparators
  input wire logic                        en,
  input wire logic                        mode_sync,
  input wire logic                        reg_cmp_trip,
  input wire logic                        hs_ilim,
  input wire logic                        ls_ilim,
  input wire logic                        vout_above_nom,
  input wire logic                        vout_above_half,
  // switch commands and limit
  input wire logic                        hs_gate,
  input wire logic                        ls_gate,
  input wire logic [bcsc_pkg::ILIM_W-1:0] ilim_ma
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] idle_cnt;

  // cycles in forced mode without a high-side pulse
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !(en && mode_sync && !ls_ilim) || hs_gate)
      idle_cnt <= 8'h00;
    else
      idle_cnt <= idle_cnt + 8'h01;
  end

  sequence s_en_off2;
    !en ##1 !en;
  endsequence
  sequence s_below_half;
    !vout_above_half [*4];
  endsequence

  AST_NO_OVERLAP: assert property (!(hs_gate && ls_gate))
    else $error("both switch commands high");
  AST_EN_OFF: assert property (!en |=> !hs_gate && !ls_gate)
    else $error("switching while disabled");
  AST_HS_LIMIT: assert property (hs_gate && hs_ilim && en |=> !hs_gate && ls_gate)
    else $error("high-side limit not obeyed");
  AST_LS_HOLD: assert property (ls_gate && ls_ilim && en |=> ls_gate && !hs_gate)
    else $error("low-side released under limit");
  AST_HS_HOLD: assert property (hs_gate && en && !reg_cmp_trip && !hs_ilim && !vout_above_nom |=> hs_gate)
    else $error("high-side ended early");
  AST_SS_RESTART: assert property (s_en_off2 |=> ilim_ma == bcsc_pkg::ILIM_STEP0_MA)
    else $error("limit not at first step");
  AST_HALF_LIMIT: assert property (s_below_half |-> ilim_ma <= bcsc_pkg::ILIM_HALF_MA)
    else $error("limit above half");
  AST_FORCED_PULSE: assert property (idle_cnt < 8'd120)
    else $error("no pulse in forced mode");
endmodule // bcsc_ctrl_monitor

bind bcsc_ctrl bcsc_ctrl_monitor i_mon (.sys_clk, .rst_n, .en, .mode_sync, .reg_cmp_trip, .hs_ilim, .ls_ilim,
  .vout_above_nom, .vout_above_half, .hs_gate, .ls_gate, .ilim_ma);

//--- bcsc_plant.sv
// behavioural regulation comparator and external sync clock
module bcsc_plant (
  // clock
  input  wire logic       sys_clk,
  // switch command and scenario controls
  input  wire logic       hs_gate,
  input  wire logic [3:0] on_len,
  input  wire logic       sync_on,
  input  wire logic       mode_lvl,
  // comparator and pin
  output logic            reg_cmp_trip,
  output logic            mode_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] on_cnt = 4'h0;
  logic [4:0] sync_cnt = 5'h00;

  initial reg_cmp_trip = 1'b0;
  initial mode_sync = 1'b0;

  // trips after on_len cycles of high-side on-time
  always @(posedge sys_clk)
  begin
    on_cnt <= hs_gate ? on_cnt + 4'h1 : 4'h0;
    reg_cmp_trip <= hs_gate && (on_cnt >= on_len);
  end

  // about 3 MHz while synchronising, else a static level
  always @(posedge sys_clk)
  begin
    sync_cnt <= (sync_cnt == 5'h10) ? 5'h00 : sync_cnt + 5'h01;
    if (!sync_on)
      mode_sync <= mode_lvl;
    else if (sync_cnt == 5'h10)
      mode_sync <= !mode_sync;
  end
endmodule // bcsc_plant

//--- bcsc_ctrl_test.sv
// self-checking bench for the converter control core
module bcsc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, en, mode_lvl, sync_on, hs_ilim, ls_ilim, light_load;
  logic        vout_below_ps, vout_above_nom, vout_above_half, reg_wr, reg_rd;
  logic        mode_sync, reg_cmp_trip, hs_gate, ls_gate, hs_q, ms_q, sync_chk;
  logic [3:0]  on_len;
  logic [7:0]  reg_addr, since;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [9:0]  ilim_ma;
  int          err_count, checks_done, seed, e;

  bcsc_ctrl #(.SS_STEP_TICKS(4)) i_dut (.sys_clk, .rst_n, .en, .mode_sync, .reg_cmp_trip, .hs_ilim, .ls_ilim,
    .vout_below_ps, .vout_above_nom, .vout_above_half, .light_load, .hs_gate, .ls_gate, .ilim_ma,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  bcsc_plant i_plant (.sys_clk, .hs_gate, .on_len, .sync_on, .mode_lvl, .reg_cmp_trip, .mode_sync);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [9:0] exp_lim(input int step, input logic above);
    logic [9:0] v;
    v = step == 0 ? bcsc_pkg::ILIM_STEP0_MA : step == 1 ? bcsc_pkg::ILIM_STEP1_MA :
        step == 2 ? bcsc_pkg::ILIM_STEP2_MA : bcsc_pkg::ILIM_FULL_MA;
    if (!above && v > bcsc_pkg::ILIM_HALF_MA)
      v = bcsc_pkg::ILIM_HALF_MA;
    return v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge sys_clk);
  endtask

  // pulse count over n cycles must lie in lo..hi
  task automatic pulses(input int n, input int lo, input int hi);
    wr(bcsc_pkg::ADDR_COUNT, 32'h0);
    cyc(n);
    rd(bcsc_pkg::ADDR_COUNT);
    chk({31'h0, int'(rv[15:0]) >= lo && int'(rv[15:0]) <= hi}, 32'h1);
  endtask

  // high-side turn-on must follow a falling sync edge closely
  always @(posedge sys_clk)
  begin
    since <= (ms_q && !mode_sync) ? 8'h00 : since + 8'h01;
    ms_q <= mode_sync;
    hs_q <= hs_gate;
    if (sync_chk && hs_gate && !hs_q)
      chk({31'h0, since <= 8'h04}, 32'h1);
  end

  initial
  begin
    {sys_clk, rst_n, en, mode_lvl, sync_on, hs_ilim, ls_ilim, light_load, sync_chk} = 9'h0;
    {vout_below_ps, vout_above_nom, vout_above_half, reg_wr, reg_rd, hs_q, ms_q} = 7'h0;
    {on_len, reg_addr, since, reg_wdata} = 52'h0;
    {err_count, checks_done, seed} = {32'h0, 32'h0, 32'h9541};
    e = 330 / bcsc_pkg::SW_PERIOD_CYC;
    cyc(20);
    rst_n <= 1'b1;
    on_len <= 4'h3;
    cyc(2);
    chk(ilim_ma, exp_lim(0, 0));
    chk({hs_gate, ls_gate}, 2'b00);
    rd(bcsc_pkg::ADDR_CTRL);
    chk(rv, bcsc_pkg::CTRL_RESET);
    rd(8'h10);
    chk(rv, 32'h0);
    en <= 1'b1;
    mode_lvl <= 1'b1;
    cyc(96);
    chk(ilim_ma, exp_lim(0, 0));
    cyc(56);
    chk(ilim_ma, exp_lim(1, 0));
    cyc(601);
    chk(ilim_ma, exp_lim(1, 0));
    vout_above_half <= 1'b1;
    cyc(301);
    chk(ilim_ma, exp_lim(3, 1));
    vout_above_half <= 1'b0;
    cyc(6);
    chk(ilim_ma, exp_lim(3, 0));
    vout_above_half <= 1'b1;
    cyc(5);
    rd(bcsc_pkg::ADDR_ILIM);
    chk(rv, {22'h0, exp_lim(3, 1)});
    rd(bcsc_pkg::ADDR_STATUS);
    chk({rv[8:7], rv[1:0]}, 4'b0111);
    $display("test soft-start done");
    {light_load, vout_above_nom} <= 2'b11;
    pulses(330, e - 1, e + 1);
    mode_lvl <= 1'b0;
    cyc(100);
    pulses(330, 0, 0);
    rd(bcsc_pkg::ADDR_STATUS);
    chk({rv[9], rv[4]}, 2'b01);
    vout_above_nom <= 1'b0;
    vout_below_ps <= 1'b1;
    cyc(2);
    vout_below_ps <= 1'b0;
    pulses(330, 1, e + 1);
    vout_above_nom <= 1'b1;
    cyc(40);
    pulses(330, 0, 0);
    light_load <= 1'b0;
    pulses(330, e - 1, e + 1);
    light_load <= 1'b1;
    wr(bcsc_pkg::ADDR_CTRL, 32'h0);
    rd(bcsc_pkg::ADDR_CTRL);
    chk(rv, 32'h0);
    pulses(330, e - 1, e + 1);
    wr(bcsc_pkg::ADDR_CTRL, 32'h1);
    $display("test modes done");
    mode_lvl <= 1'b1;
    ls_ilim <= 1'b1;
    cyc(100);
    pulses(200, 0, 0);
    {ls_ilim, hs_ilim, on_len} <= 6'h1f;
    pulses(330, e - 1, e + 1);
    chk({31'h0, rv[31:16] <= rv[15:0] + 16'h1 && rv[15:0] <= rv[31:16] + 16'h1}, 32'h1);
    {hs_ilim, on_len, mode_lvl, sync_on} <= 7'h07;
    cyc(100);
    sync_chk <= 1'b1;
    pulses(340, 9, 11);
    rd(bcsc_pkg::ADDR_STATUS);
    chk({rv[9], rv[6], rv[4]}, 3'b110);
    sync_chk <= 1'b0;
    sync_on <= 1'b0;
    $display("test limits and sync done");
    repeat (3000)
    begin
      @(posedge sys_clk);
      rv = $random(seed);
      {hs_ilim, ls_ilim} <= {rv[2:0] == 3'h0, rv[6:3] == 4'h0};
      {vout_below_ps, vout_above_nom, vout_above_half, light_load} <= rv[11:8];
      on_len <= rv[15:12];
      if (rv[21:16] == 6'h0)
        mode_lvl <= ~mode_lvl;
      en <= rv[31:24] != 8'h0;
    end
    en <= 1'b0;
    cyc(4);
    chk({hs_gate, ls_gate}, 2'b00);
    chk(ilim_ma, exp_lim(0, 0));
    $display("test random done");
    results();
  end

  initial
  begin
    cyc(100000);
    err_count++;
    results();
  end
endmodule // bcsc_ctrl_test
